/* File: core/psf_pkg.sv */
// Purpose: Constants and carrier types for the PLL status and feedback register slice
// Assumes: One 50 MHz clock, registers reached through the serial control port's internal access port
// Notes:   Byte-wide registers, byte addresses
package psf_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] PSF_ADDR_STATE    = 8'h44;
  localparam logic [7:0] PSF_ADDR_FB_CTRL  = 8'h45;
  localparam logic [7:0] PSF_ADDR_OUT_PWR  = 8'h46;
  localparam logic [7:0] PSF_ADDR_BOUND0   = 8'h47;
  localparam logic [7:0] PSF_ADDR_BOUND1   = 8'h48;

  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] PSF_RST_STATE     = 8'h00;
  localparam logic [7:0] PSF_RST_FB_CTRL   = 8'h00;
  localparam logic [7:0] PSF_RST_OUT_PWR   = 8'h00;
  localparam logic [7:0] PSF_RST_BOUND     = 8'h02;
  localparam int         PSF_BIT_HOLDOVER  = 0;
  localparam int         PSF_BIT_LOCK      = 1;
  localparam int         PSF_BIT_FB_SRC    = 2;
  localparam int         PSF_BIT_FB_ON     = 7;
  localparam int         PSF_NUM_DIFF_OUT  = 4;
  localparam logic [7:0] PSF_MASK_STATE    = 8'h03;
  localparam logic [7:0] PSF_MASK_FB_CTRL  = 8'h84;
  localparam logic [7:0] PSF_MASK_OUT_PWR  = 8'h0f;
  localparam logic [7:0] PSF_RD_UNMAPPED   = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int PSF_CLK_PERIOD_NS  = 20;
  localparam int PSF_BOUND_STEP_US  = 10;
  localparam int PSF_BOUND_STEP_CYC = (PSF_BOUND_STEP_US * 1000) / PSF_CLK_PERIOD_NS;
  localparam int PSF_BOUND_CYC_W    = 17;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psf_reg_req_t;

  typedef struct packed {
    logic auto_mode;
    logic input0_avail;
    logic input1_avail;
    logic input1_first;
  } psf_ref_sel_t;

endpackage

/* File: core/psf_regs.sv */
// Purpose: PLL state flags, external feedback control, output power and phase memory bound registers
// Assumes: Register port is synchronous to mclk; PLL status levels arrive from another domain
// Notes:   Read data appears one cycle after the read strobe; reading the state register clears it
module psf_regs
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Register access port
  input  wire psf_pkg::psf_reg_req_t reg_req,
  output logic [7:0]                 rd_data_r,
  output logic                       rd_valid_r,
  // PLL condition inputs, asynchronous
  input  wire logic                  pll_in_holdover,
  input  wire logic                  pll_locked,
  // Reference choice inputs, same domain
  input  wire psf_pkg::psf_ref_sel_t ref_sel,
  // Controls to the clock path
  output logic                       feedback_source_choice_r,
  output logic                       feedback_path_on_r,
  output logic [3:0]                 diff_out_low_power_r,
  output logic [7:0]                 input0_phase_bound_value_r,
  output logic [7:0]                 input1_phase_bound_value_r,
  output logic [psf_pkg::PSF_BOUND_CYC_W-1:0] input0_bound_cycles_r,
  output logic [psf_pkg::PSF_BOUND_CYC_W-1:0] input1_bound_cycles_r,
  output logic                       holdover_request_r,
  output logic                       selected_ref_r
);

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [1:0] hold_sync_r;
  logic [1:0] lock_sync_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_sync_r <= 2'h0;
      lock_sync_r <= 2'h0;
    end
    else
    begin
      hold_sync_r <= {hold_sync_r[0], pll_in_holdover};
      lock_sync_r <= {lock_sync_r[0], pll_locked};
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic wr_fb;
  logic wr_pwr;
  logic wr_b0;
  logic wr_b1;
  logic rd_state;

  assign wr_fb    = reg_req.wr && (reg_req.addr == psf_pkg::PSF_ADDR_FB_CTRL);
  assign wr_pwr   = reg_req.wr && (reg_req.addr == psf_pkg::PSF_ADDR_OUT_PWR);
  assign wr_b0    = reg_req.wr && (reg_req.addr == psf_pkg::PSF_ADDR_BOUND0);
  assign wr_b1    = reg_req.wr && (reg_req.addr == psf_pkg::PSF_ADDR_BOUND1);
  assign rd_state = reg_req.rd && (reg_req.addr == psf_pkg::PSF_ADDR_STATE);

  // ------------------------------------------------------------
  // Sticky PLL state flags
  // ------------------------------------------------------------
  // No mask path feeds these; a new event in the clearing read cycle wins
  logic [7:0] state_r;
  logic [7:0] state_nxt;
  logic [7:0] state_ev;

  always_comb
  begin
    state_ev                            = 8'h00;
    state_ev[psf_pkg::PSF_BIT_HOLDOVER] = hold_sync_r[1];
    state_ev[psf_pkg::PSF_BIT_LOCK]     = lock_sync_r[1];
    state_nxt = (state_ev | (rd_state ? 8'h00 : state_r)) & psf_pkg::PSF_MASK_STATE;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_r <= psf_pkg::PSF_RST_STATE;
    else
      state_r <= state_nxt;
  end

  // ------------------------------------------------------------
  // Feedback control
  // ------------------------------------------------------------
  logic [7:0] fb_ctrl_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fb_ctrl_r <= psf_pkg::PSF_RST_FB_CTRL;
    else if (wr_fb)
      fb_ctrl_r <= reg_req.wdata & psf_pkg::PSF_MASK_FB_CTRL;
  end

  // Source choice follows its register bit whether the path is on or off
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      feedback_source_choice_r <= 1'b0;
      feedback_path_on_r       <= 1'b0;
    end
    else
    begin
      feedback_source_choice_r <= fb_ctrl_r[psf_pkg::PSF_BIT_FB_SRC];
      feedback_path_on_r       <= fb_ctrl_r[psf_pkg::PSF_BIT_FB_ON];
    end
  end

  // ------------------------------------------------------------
  // Output power
  // ------------------------------------------------------------
  logic [7:0] out_pwr_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      out_pwr_r <= psf_pkg::PSF_RST_OUT_PWR;
    else if (wr_pwr)
      out_pwr_r <= reg_req.wdata & psf_pkg::PSF_MASK_OUT_PWR;
  end

  generate
    for (genvar gi = 0; gi < psf_pkg::PSF_NUM_DIFF_OUT; gi++)
    begin : g_pwr
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          diff_out_low_power_r[gi] <= 1'b0;
        else
          diff_out_low_power_r[gi] <= out_pwr_r[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Phase memory bounds
  // ------------------------------------------------------------
  // Software must keep each bound at least one reference period; not checked here
  localparam logic [psf_pkg::PSF_BOUND_CYC_W-1:0] STEP_CYC = psf_pkg::PSF_BOUND_CYC_W'(psf_pkg::PSF_BOUND_STEP_CYC);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      input0_phase_bound_value_r <= psf_pkg::PSF_RST_BOUND;
      input1_phase_bound_value_r <= psf_pkg::PSF_RST_BOUND;
    end
    else
    begin
      if (wr_b0)
        input0_phase_bound_value_r <= reg_req.wdata;
      if (wr_b1)
        input1_phase_bound_value_r <= reg_req.wdata;
    end
  end

  // Step count in mclk cycles; lags the register by one cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      input0_bound_cycles_r <= '0;
      input1_bound_cycles_r <= '0;
    end
    else
    begin
      input0_bound_cycles_r <= psf_pkg::PSF_BOUND_CYC_W'(input0_phase_bound_value_r * STEP_CYC);
      input1_bound_cycles_r <= psf_pkg::PSF_BOUND_CYC_W'(input1_phase_bound_value_r * STEP_CYC);
    end
  end

  // ------------------------------------------------------------
  // Automatic reference choice
  // ------------------------------------------------------------
  logic sel_nxt;

  always_comb
  begin
    if (ref_sel.input0_avail && ref_sel.input1_avail)
      sel_nxt = ref_sel.input1_first;
    else if (ref_sel.input1_avail)
      sel_nxt = 1'b1;
    else if (ref_sel.input0_avail)
      sel_nxt = 1'b0;
    else
      sel_nxt = selected_ref_r;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      holdover_request_r <= 1'b0;
      selected_ref_r     <= 1'b0;
    end
    else if (ref_sel.auto_mode)
    begin
      holdover_request_r <= !ref_sel.input0_avail && !ref_sel.input1_avail;
      selected_ref_r     <= sel_nxt;
    end
    else
      holdover_request_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_req.addr)
      psf_pkg::PSF_ADDR_STATE:   rd_mux = state_r;
      psf_pkg::PSF_ADDR_FB_CTRL: rd_mux = fb_ctrl_r;
      psf_pkg::PSF_ADDR_OUT_PWR: rd_mux = out_pwr_r;
      psf_pkg::PSF_ADDR_BOUND0:  rd_mux = input0_phase_bound_value_r;
      psf_pkg::PSF_ADDR_BOUND1:  rd_mux = input1_phase_bound_value_r;
      default:                   rd_mux = psf_pkg::PSF_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= reg_req.rd;
      if (reg_req.rd)
        rd_data_r <= rd_mux;
    end
  end

endmodule

/* File: test/psf_host.sv */
// Purpose: Host software model driving the register port
// Assumes: One strobe cycle per access, read answer one edge later
// Notes:   Idle address and data are scrambled so stale values never look valid
module psf_host
(
  // Clock
  input wire logic                  mclk,
  // Register port
  output psf_pkg::psf_reg_req_t     reg_req,
  input wire logic [7:0]            rd_data_r,
  input wire logic                  rd_valid_r
);
  timeunit 1ns;
  timeprecision 1ns;

  initial reg_req = '0;

  // Callers enable feedback only with frequency-locked sources
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge mclk);
    reg_req = {wr, !wr, addr, wd};
    @(negedge mclk);
    rd = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
    reg_req = {2'b00, ~addr, ~wd};
  endtask
endmodule

/* File: test/psf_regs_monitor.sv */
// Purpose: Port-level checker for the PLL status and feedback register slice
// Assumes: Single mclk domain, resetn asynchronous active low
// Notes:   Attached to psf_regs by the bind at the foot
module psf_regs_monitor
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  resetn,
  // Register port and PLL inputs
  input wire psf_pkg::psf_reg_req_t reg_req,
  input wire logic [7:0]            rd_data_r,
  input wire logic                  pll_in_holdover,
  input wire logic                  pll_locked,
  input wire psf_pkg::psf_ref_sel_t ref_sel,
  // Controls
  input wire logic                  feedback_source_choice_r,
  input wire logic                  feedback_path_on_r,
  input wire logic [3:0]            diff_out_low_power_r,
  input wire logic [7:0]            input0_phase_bound_value_r,
  input wire logic [7:0]            input1_phase_bound_value_r,
  input wire logic                  holdover_request_r,
  input wire logic                  selected_ref_r
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_fb_source: assert property (reg_req.wr && reg_req.addr == 8'h45 |=> ##1
    feedback_source_choice_r == $past(reg_req.wdata[2], 2)) else $error("feedback source wrong");
  a_fb_enable: assert property (reg_req.wr && reg_req.addr == 8'h45 |=> ##1
    feedback_path_on_r == $past(reg_req.wdata[7], 2)) else $error("feedback enable wrong");
  a_out_power: assert property (reg_req.wr && reg_req.addr == 8'h46 |=> ##1
    diff_out_low_power_r == $past(reg_req.wdata[3:0], 2)) else $error("output power wrong");
  a_bound_zero: assert property (reg_req.wr && reg_req.addr == 8'h47 |=>
    input0_phase_bound_value_r == $past(reg_req.wdata)) else $error("bound 0 wrong");
  a_bound_one: assert property (reg_req.wr && reg_req.addr == 8'h48 |=>
    input1_phase_bound_value_r == $past(reg_req.wdata)) else $error("bound 1 wrong");
  a_lock_flag: assert property (pll_locked [*5] ##0 (reg_req.rd && reg_req.addr == 8'h44) |=>
    rd_data_r[1]) else $error("lock flag missing");
  a_hold_flag: assert property (pll_in_holdover [*5] ##0 (reg_req.rd && reg_req.addr == 8'h44) |=>
    rd_data_r[0]) else $error("holdover flag missing");
  a_hold_request: assert property (ref_sel.auto_mode |=>
    holdover_request_r == !($past(ref_sel.input0_avail) || $past(ref_sel.input1_avail)))
    else $error("holdover wrong");
  a_ref_pick: assert property (ref_sel.auto_mode && ref_sel.input0_avail && !ref_sel.input1_avail |=>
    !selected_ref_r) else $error("reference choice wrong");
endmodule

bind psf_regs psf_regs_monitor i_mon (.mclk, .resetn, .reg_req, .rd_data_r, .pll_in_holdover, .pll_locked,
  .ref_sel, .feedback_source_choice_r, .feedback_path_on_r, .diff_out_low_power_r,
  .input0_phase_bound_value_r, .input1_phase_bound_value_r, .holdover_request_r, .selected_ref_r);

/* File: test/tb.sv */
// Purpose: Self-checking bench for the PLL status and feedback register slice
// Assumes: Host model drives the register port at falling edges
// Notes:   Register contents kept in an array model beside the design
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  mclk;
  logic                  resetn;
  logic                  pll_in_holdover;
  logic                  pll_locked;
  logic                  rd_valid_r;
  logic                  feedback_source_choice_r;
  logic                  feedback_path_on_r;
  logic                  holdover_request_r;
  logic                  selected_ref_r;
  logic                  exp_sel;
  logic [3:0]            diff_out_low_power_r;
  logic [7:0]            rd_data_r;
  logic [7:0]            input0_phase_bound_value_r;
  logic [7:0]            input1_phase_bound_value_r;
  logic [7:0]            d;
  logic [7:0]            rdv;
  logic [7:0]            m [5];
  logic [16:0]           input0_bound_cycles_r;
  logic [16:0]           input1_bound_cycles_r;
  psf_pkg::psf_reg_req_t reg_req;
  psf_pkg::psf_ref_sel_t ref_sel;
  int                    failures;
  int                    n_checks;
  int                    a;
  localparam logic [7:0] MASK [5] = '{8'h00, 8'h84, 8'h0f, 8'hff, 8'hff};

  psf_regs i_dut (.mclk, .resetn, .reg_req, .rd_data_r, .rd_valid_r, .pll_in_holdover, .pll_locked,
    .ref_sel, .feedback_source_choice_r, .feedback_path_on_r, .diff_out_low_power_r,
    .input0_phase_bound_value_r, .input1_phase_bound_value_r, .input0_bound_cycles_r,
    .input1_bound_cycles_r, .holdover_request_r, .selected_ref_r);
  psf_host i_host (.mclk, .reg_req, .rd_data_r, .rd_valid_r);

  initial
  begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    i_host.xfer(1'b0, addr, 8'h00, v);
    chk(17'(v), 17'(exp));
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run is under 150 cycles; allow twenty times that
  initial
  begin
    #(3000 * 20);
    failures++;
    final_report();
  end

  initial
  begin
    resetn = 0;
    pll_in_holdover = 0;
    pll_locked = 0;
    ref_sel = '0;
    exp_sel = 0;
    void'($urandom(29577));
    repeat (2) @(negedge mclk);
    resetn = 1;
    m = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02};
    for (a = 0; a < 5; a++)
      rdchk(8'h44 + 8'(a), m[a]);
    rdchk(8'h49, 8'h00);
    chk(input0_bound_cycles_r, 17'(m[3]) * 17'd500);
    chk(input1_bound_cycles_r, 17'(m[4]) * 17'd500);
    $display("test reset values done");
    // Random writes, the read-only place included
    for (int i = 0; i < 16; i++)
    begin
      a = $urandom_range(4);
      d = 8'($urandom_range(255, 1));
      i_host.xfer(1'b1, 8'h44 + 8'(a), d, rdv);
      m[a] = d & MASK[a];
      @(negedge mclk);
      chk(17'(feedback_path_on_r), 17'(m[1][7]));
      chk(17'(feedback_source_choice_r), 17'(m[1][2]));
      chk(17'(diff_out_low_power_r), 17'(m[2][3:0]));
      chk(input0_bound_cycles_r, 17'(m[3]) * 17'd500);
      chk(input1_bound_cycles_r, 17'(m[4]) * 17'd500);
      chk(17'(input0_phase_bound_value_r), 17'(m[3]));
      chk(17'(input1_phase_bound_value_r), 17'(m[4]));
      rdchk(8'h44 + 8'(a), m[a]);
    end
    $display("test register writes done");
    pll_locked = 1;
    pll_in_holdover = 1;
    repeat (5) @(negedge mclk);
    rdchk(8'h44, 8'h03);
    pll_in_holdover = 0;
    repeat (5) @(negedge mclk);
    rdchk(8'h44, 8'h03);
    rdchk(8'h44, 8'h02);
    pll_locked = 0;
    repeat (5) @(negedge mclk);
    rdchk(8'h44, 8'h02);
    rdchk(8'h44, 8'h00);
    $display("test state flags done");
    for (int k = 0; k < 24; k++)
    begin
      ref_sel = (k < 16) ? 4'(k) : 4'($urandom);
      @(negedge mclk);
      if (ref_sel.auto_mode && (ref_sel.input0_avail || ref_sel.input1_avail))
        exp_sel = (ref_sel.input0_avail && ref_sel.input1_avail) ? ref_sel.input1_first : ref_sel.input1_avail;
      chk(17'(holdover_request_r), 17'(ref_sel.auto_mode && !(ref_sel.input0_avail || ref_sel.input1_avail)));
      chk(17'(selected_ref_r), 17'(exp_sel));
    end
    $display("test reference choice done");
    final_report();
  end
endmodule
